// ==== verilog/ebg_defines.vh ====
/*
 register map, field layout, reset values and timing constants of the
 bank-gap and hard-reset block. assumes a 32-bit avalon-mm word bus with
 a word-index address.
*/
`ifndef EBG_DEFINES_VH
`define EBG_DEFINES_VH

// register word indices
`define EBG_ADDR_W          2
`define EBG_IDX_BANK        2'h0
`define EBG_IDX_REV         2'h1
`define EBG_IDX_HRST        2'h2
`define EBG_IDX_CTRL        2'h3

// bank_switch_control fields
`define EBG_ZONE_LSB        0
`define EBG_ZONE_MSB        2
`define EBG_GAP_LSB         3
`define EBG_GAP_MSB         5
`define EBG_GAP_RST         3'h7
`define EBG_ZONE_RST        3'h7
`define EBG_ZONE_0          3'h0
`define EBG_ZONE_6          3'h6
`define EBG_ZONE_7          3'h7

// hard_reset_command and control register fields
`define EBG_HRST_BIT        30
`define EBG_CTRL_PWE_BIT    0

// revision value, arbitrary
`define EBG_REVISION        16'h0001
`define EBG_REV_MSB         15
`define EBG_REV_LSB         0

// gap counter end points and the all-zero read word
`define EBG_GAP_NONE        3'h0
`define EBG_GAP_LAST        3'h1
`define EBG_WORD_ZERO       32'h0000_0000

// timing clock is the system clock divided by two
`define EBG_TCLK_DIV        1'h1

`endif

// ==== verilog/ebg_bank_gap.v ====
/*
 bank-switch gap insertion, revision readout and software hard reset for
 an external memory interface, behind an avalon-mm slave.
 assumes accesses are offered by the wider interface as a valid/zone pair
 held until taken; one access is launched per accepted request.
 assumes the timing clock is an enable pulse on every second system clock,
 so a gap of n timing cycles spans about 2n system cycles, the phase of
 the divider deciding the last one.
 assumes the ready pin is asynchronous to the system clock.
 assumes software writes only the zone codes that select a zone.
*/
// Design decisions made here: the Avalon-MM register port and the address map.
// How it works
// RULE_01: idle timing-clock cycles inserted when an access enters or leaves the zone.
// RULE_02: gap field is a binary count, zero to seven timing cycles.
// RULE_03: reset loads gap field with seven timing cycles, fourteen system cycles.
// RULE_04: three-bit zone field picks the single bank-switched zone.
// RULE_05: zone codes 000, 110, 111 valid; 001 to 101 reserved.
// RULE_06: reset selects zone seven as the bank-switched zone.
// RULE_07: bank and hard-reset writes only land while protected writes are enabled.
// RULE_08: sixteen-bit read-only revision field, informational only.
// RULE_09: writing zero to hard-reset bit does nothing; it reads zero.
// RULE_10: writing one restores defaults and drives interface outputs inactive.
// RULE_11: hard reset drops any access in progress or pending, unfinished.
// RULE_12: hard reset releases any stall held on the DMA requester.
// RULE_13: processor should hard reset when ready sticks low during DMA.
// RULE_14: peripheral drives ready high when it can finish the access.
// RULE_15: reserved bits read zero and ignore writes.
// RULE_16: no gap between accesses on the same side of the zone.
`timescale 1ns/1ps
`include "ebg_defines.vh"

module ebg_bank_gap (
  // clock and reset
  input  wire                   clk_sys_i,
  input  wire                   rst_i,
  // avalon-mm slave
  input  wire [`EBG_ADDR_W-1:0] avs_address_i,
  input  wire                   avs_read_i,
  input  wire                   avs_write_i,
  input  wire [31:0]            avs_writedata_i,
  output reg  [31:0]            avs_readdata_o,
  output reg                    avs_waitrequest_o,
  // access requests from the interface sequencer
  input  wire                   acc_valid_i,
  input  wire [2:0]             acc_zone_i,
  input  wire                   dma_req_i,
  input  wire                   ext_ready_i,
  // access launch and status
  output reg                    acc_start_o,
  output reg                    acc_ready_o,
  output reg                    gap_busy_o,
  output reg                    dma_stall_o,
  output reg                    force_interface_reinit_o,
  output reg  [2:0]             bank_zone_o,
  output reg  [2:0]             bank_gap_cycles_o
);

  // is a zone code one of the decodable zones
  function zone_legal;
    input [2:0] z;
    begin
      zone_legal = (z == `EBG_ZONE_0) || (z == `EBG_ZONE_6) ||
                   (z == `EBG_ZONE_7);
    end
  endfunction

  // does the bus address select the given register word
  function reg_hit;
    input [`EBG_ADDR_W-1:0] a;
    input [`EBG_ADDR_W-1:0] idx;
    begin
      reg_hit = (a == idx);
    end
  endfunction

  // gap sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_GAP  = 2'h1;
  localparam ST_ACC  = 2'h2;

  // control fields
  reg  [2:0]  gap_r;
  reg  [2:0]  zone_r;
  reg         pwe_r;

  // gap sequencer
  reg  [1:0]  st_r;
  reg  [1:0]  st_nxt;
  reg  [2:0]  cnt_r;
  reg  [2:0]  cnt_nxt;
  reg         launch;

  // timing enable and zone history of the last launched access
  reg         tdiv_r;
  reg         have_last_r;
  reg         last_in_r;

  // ready synchroniser stages
  reg         rdy_s1_r;
  reg         rdy_s2_r;

  // bus handshake and register decode
  wire        tick;
  wire        bus_wr;
  wire        bus_rd;
  wire        wr_bank;
  wire        wr_hrst;
  wire        wr_ctrl;
  wire        hrst_fire;
  wire        in_zone;
  wire        crossing;

  // a read is taken when it arrives, so its data stand in the answer
  // cycle; a write lands only at the edge where waitrequest is low, the
  // one edge at which the master is sure to still hold it
  assign bus_wr    = avs_write_i & ~avs_waitrequest_o;
  assign bus_rd    = avs_read_i & avs_waitrequest_o;

  // one timing-clock enable every second system clock
  assign tick      = tdiv_r;

  // register writes; bank and hard-reset words are protected
  assign wr_bank   = bus_wr && pwe_r &&
                     reg_hit(avs_address_i, `EBG_IDX_BANK); // see RULE_07
  assign wr_hrst   = bus_wr && pwe_r &&
                     reg_hit(avs_address_i, `EBG_IDX_HRST); // see RULE_07
  assign wr_ctrl   = bus_wr && reg_hit(avs_address_i, `EBG_IDX_CTRL);
  assign hrst_fire = wr_hrst && avs_writedata_i[`EBG_HRST_BIT]; // see RULE_09

  // side of the selected zone that the offered access lies on
  assign in_zone   = (acc_zone_i == zone_r); // see RULE_04
  assign crossing  = have_last_r && (in_zone != last_in_r); // see RULE_16

  // waitrequest drops for exactly one cycle per request
  // a request is answered one cycle after it is taken, never later
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i | avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // timing clock enable, half the system rate
  // a hard reset leaves the divider phase alone
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tdiv_r <= 1'b0;
    end else begin
      tdiv_r <= tdiv_r ^ `EBG_TCLK_DIV;
    end
  end

  // ready pin synchroniser
  // only the second stage is read by the sequencer
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end else begin
      rdy_s1_r <= ext_ready_i;
      rdy_s2_r <= rdy_s1_r; // see RULE_14
    end
  end

  // control registers; hard reset restores defaults
  // reserved zone codes are dropped; the gap field is still written
  always @(posedge clk_sys_i) begin
    if (rst_i || hrst_fire) begin
      gap_r  <= `EBG_GAP_RST;  // see RULE_03, RULE_10
      zone_r <= `EBG_ZONE_RST; // see RULE_06, RULE_10
    end else if (wr_bank) begin
      gap_r <= avs_writedata_i[`EBG_GAP_MSB:`EBG_GAP_LSB]; // see RULE_07
      if (zone_legal(avs_writedata_i[`EBG_ZONE_MSB:`EBG_ZONE_LSB])) begin
        zone_r <= avs_writedata_i[`EBG_ZONE_MSB:`EBG_ZONE_LSB]; // see RULE_05
      end
    end
  end

  // protected write enable, an unprotected control register
  // left open so software can raise it; a hard reset leaves it alone
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pwe_r <= 1'b0;
    end else if (wr_ctrl) begin
      pwe_r <= avs_writedata_i[`EBG_CTRL_PWE_BIT];
    end
  end

  // read mux; reserved bits and the hard-reset bit read zero
  // read data are held until the next read is taken
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_readdata_o <= `EBG_WORD_ZERO;
    end else if (bus_rd) begin
      avs_readdata_o <= `EBG_WORD_ZERO; // see RULE_15
      case (avs_address_i)
        `EBG_IDX_BANK: begin
          avs_readdata_o[`EBG_GAP_MSB:`EBG_GAP_LSB]   <= gap_r;
          avs_readdata_o[`EBG_ZONE_MSB:`EBG_ZONE_LSB] <= zone_r;
        end
        `EBG_IDX_REV: begin
          avs_readdata_o[`EBG_REV_MSB:`EBG_REV_LSB] <= `EBG_REVISION; // see RULE_08
        end
        `EBG_IDX_HRST: begin
          avs_readdata_o <= `EBG_WORD_ZERO; // see RULE_09
        end
        `EBG_IDX_CTRL: begin
          avs_readdata_o[`EBG_CTRL_PWE_BIT] <= pwe_r;
        end
        default: begin
          avs_readdata_o <= `EBG_WORD_ZERO;
        end
      endcase
    end
  end

  // gap sequencer: counts timing-clock ticks before a crossing access
  // acc_valid_i must fall after acc_start_o, or the same access is
  // launched again once it completes
  always @* begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    launch  = 1'b0;
    case (st_r)
      // idle: launch at once unless the access crosses the zone edge with a nonzero gap
      ST_IDLE: begin
        if (acc_valid_i) begin
          if (crossing && (gap_r != `EBG_GAP_NONE)) begin
            st_nxt  = ST_GAP;          // see RULE_01
            cnt_nxt = gap_r;           // see RULE_02
          end else begin
            launch = 1'b1;             // see RULE_16
            st_nxt = ST_ACC;
          end
        end
      end
      // gap: count timing ticks; the access launches on the last one
      ST_GAP: begin
        if (tick) begin
          if (cnt_r == `EBG_GAP_LAST) begin
            launch = 1'b1;
            st_nxt = ST_ACC;
          end
          cnt_nxt = cnt_r - `EBG_GAP_LAST;
        end
      end
      // access: wait for the synchronised ready
      ST_ACC: begin
        if (rdy_s2_r) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer state; hard reset drops the pending access
  // history is cleared too, so the first access after it gets no gap
  always @(posedge clk_sys_i) begin
    if (rst_i || hrst_fire) begin
      st_r        <= ST_IDLE;  // see RULE_11
      cnt_r       <= `EBG_GAP_NONE;
      have_last_r <= 1'b0;
      last_in_r   <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      if (launch) begin
        have_last_r <= 1'b1;
        last_in_r   <= in_zone;
      end
    end
  end

  // registered outputs; all but the reinit pulse and the default-loaded field copies inactive after a hard reset
  // the reinit pulse marks the one cycle after a hard-reset write lands;
  // dma stall stands while dma is requested and an access is waiting or in flight, and the
  // field copies trail the control registers by one cycle
  always @(posedge clk_sys_i) begin
    if (rst_i || hrst_fire) begin
      acc_start_o              <= 1'b0; // see RULE_10, RULE_11
      acc_ready_o              <= 1'b0;
      gap_busy_o               <= 1'b0;
      dma_stall_o              <= 1'b0; // see RULE_12
      force_interface_reinit_o <= hrst_fire;
      bank_zone_o              <= `EBG_ZONE_RST;
      bank_gap_cycles_o        <= `EBG_GAP_RST;
    end else begin
      acc_start_o              <= launch;
      acc_ready_o              <= (st_r == ST_ACC) && rdy_s2_r;
      gap_busy_o               <= (st_nxt == ST_GAP);
      dma_stall_o              <= dma_req_i && (st_nxt != ST_IDLE);
      force_interface_reinit_o <= 1'b0;
      bank_zone_o              <= zone_r;
      bank_gap_cycles_o        <= gap_r;
    end
  end

endmodule // ebg_bank_gap

// ==== bench/ebg_bank_gap_checker.sv ====
/* port assertions for the bank-gap block.
   assumes it is bound to every ebg_bank_gap instance. */
`timescale 1ns/1ps
`include "ebg_defines.vh"
module ebg_bank_gap_checker (
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [1:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        gap_busy_o,
  input wire logic        dma_stall_o,
  input wire logic        force_interface_reinit_o,
  input wire logic [2:0]  bank_zone_o,
  input wire logic [2:0]  bank_gap_cycles_o
);
  wire rq = avs_read_i && avs_waitrequest_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // field defaults and gap length
  reset_dflt_a: assert property (
    $fell(rst_i) |-> bank_zone_o == `EBG_ZONE_RST
    && bank_gap_cycles_o == `EBG_GAP_RST) else $error("reset fields");
  gap_bound_a: assert property (
    $rose(gap_busy_o) |-> ##[1:16] !gap_busy_o) else $error("gap too long");
  zone_code_a: assert property (
    bank_zone_o inside {3'h0, 3'h6, 3'h7}) else $error("zone code");
  // read answers
  hrst_zero_a: assert property (
    rq && avs_address_i == `EBG_IDX_HRST |=> avs_readdata_o == 32'h0)
    else $error("reset word");
  rev_value_a: assert property (
    rq && avs_address_i == `EBG_IDX_REV
    |=> avs_readdata_o == {16'h0, `EBG_REVISION}) else $error("revision");
  bank_resv_a: assert property (
    rq && avs_address_i == `EBG_IDX_BANK |=> avs_readdata_o[31:6] == 26'h0)
    else $error("reserved bits");
  // hard reset effects
  reinit_dflt_a: assert property (
    force_interface_reinit_o |-> ##[0:2] (bank_zone_o == `EBG_ZONE_RST
    && bank_gap_cycles_o == `EBG_GAP_RST)) else $error("reinit fields");
  reinit_rel_a: assert property (
    force_interface_reinit_o |-> ##[0:1] (!dma_stall_o && !gap_busy_o))
    else $error("reinit release");
endmodule // ebg_bank_gap_checker

bind ebg_bank_gap ebg_bank_gap_checker ebg_bank_gap_checker_inst (
  .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_waitrequest_o,
  .avs_readdata_o, .gap_busy_o, .dma_stall_o, .force_interface_reinit_o,
  .bank_zone_o, .bank_gap_cycles_o);

// ==== bench/ebg_ext_periph.sv ====
/* far-side peripheral: answers each launched access with ready.
   assumes launches are one-cycle pulses on the system clock. */
`timescale 1ns/1ps
module ebg_ext_periph (
  // clock, reset and launch
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic acc_start_i,
  input  wire logic slow_i,
  // ready pin, low while not answering
  output logic      ext_ready_o = 1'h0
);
  int cnt = 0;
  // counts down after a launch; ready stands one cycle as the count ends,
  // since a longer ready would still sit in the synchroniser and finish
  // the next access as soon as it starts
  always @(posedge clk_sys_i) begin
    if (rst_i)
      cnt <= 0;
    else if (acc_start_i)
      cnt <= slow_i ? 48 : 8;
    else if (cnt > 0)
      cnt <= cnt - 1;
    ext_ready_o <= cnt == 1;
  end
endmodule // ebg_ext_periph

// ==== bench/ebg_bank_gap_test.sv ====
/* self-checking bench for the bank-gap block.
   assumes the checker and peripheral model are compiled first. */
`timescale 1ns/1ps
`include "ebg_defines.vh"
module ebg_bank_gap_test;
  logic        clk_sys_i = 0, rst_i = 1, rd = 0, wr = 0, av = 0;
  logic        dma = 0, slow = 0;
  logic [1:0]  adr = '0;
  logic [31:0] wd = '0;
  logic [2:0]  az = '0;
  wire  [31:0] rdata;
  wire         wreq, start, done, busy, stall, rei, rdy;
  wire  [2:0]  bz, bg;
  logic [31:0] exp_q[$];
  int          fails = 0, comparisons = 0, seed = 58234, n, g;

  always #10 clk_sys_i = ~clk_sys_i;

  ebg_bank_gap ebg_bank_gap_inst (.clk_sys_i, .rst_i, .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .acc_valid_i(av),
    .acc_zone_i(az), .dma_req_i(dma), .ext_ready_i(rdy), .acc_start_o(start),
    .acc_ready_o(done), .gap_busy_o(busy), .dma_stall_o(stall),
    .force_interface_reinit_o(rei), .bank_zone_o(bz), .bank_gap_cycles_o(bg));
  ebg_ext_periph ebg_ext_periph_inst (.clk_sys_i, .rst_i, .acc_start_i(start),
    .slow_i(slow), .ext_ready_o(rdy));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one bounded clock step of any wait
  task automatic tick();
    @(posedge clk_sys_i);
    n++;
    if (n > 60) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do tick(); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rdq(input logic [1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // offers an access and checks the launch delay against the gap count
  task automatic acc(input logic [2:0] z, input int gc);
    av <= 1'b1;
    az <= z;
    n = 0;
    do tick(); while (start !== 1'b1);
    av <= 1'b0;
    check({31'h0, n >= 2 * gc && n <= 2 * gc + 3}, 32'h1);
    n = 0;
    do tick(); while (done !== 1'b1);
  endtask

  // compares each read answer with the oldest expected value
  always @(posedge clk_sys_i)
    if (rd && wreq === 1'b0) check(rdata, exp_q.pop_front());

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rdq(`EBG_IDX_BANK, 32'h3F);
    rdq(`EBG_IDX_REV, {16'h0, `EBG_REVISION});
    rdq(`EBG_IDX_HRST, 32'h0);
    bus(1'b1, `EBG_IDX_BANK, 32'h0);
    rdq(`EBG_IDX_BANK, 32'h3F);
    acc(3'h0, 0);
    acc(3'h0, 0);
    acc(3'h7, 7);
    acc(3'h6, 7);
    bus(1'b1, `EBG_IDX_CTRL, 32'h1);
    for (g = 0; g < 8; g++) begin
      bus(1'b1, `EBG_IDX_BANK, ($random(seed) & 32'hFFFF_FFC0) | 32'(g << 3));
      rdq(`EBG_IDX_BANK, 32'(g << 3));
      check({26'h0, bg, bz}, 32'(g << 3));
      acc(3'h0, g);
      acc(3'h6, g);
    end
    for (g = 1; g < 8; g++) begin
      bus(1'b1, `EBG_IDX_BANK, 32'(g | 8));
      rdq(`EBG_IDX_BANK, g < 6 ? 32'h08 : 32'(g | 8));
    end
    bus(1'b1, `EBG_IDX_HRST, 32'hBFFF_FFFF);
    check({31'h0, rei}, 32'h0);
    rdq(`EBG_IDX_BANK, 32'h0F);
    // hard reset written while protected writes are off is ignored
    bus(1'b1, `EBG_IDX_CTRL, 32'h0);
    bus(1'b1, `EBG_IDX_HRST, 32'h4000_0000);
    check({31'h0, rei}, 32'h0);
    rdq(`EBG_IDX_BANK, 32'h0F);
    bus(1'b1, `EBG_IDX_CTRL, 32'h1);
    // ready stuck low in a dma transfer, then a hard reset
    dma <= 1'b1;
    slow <= 1'b1;
    av <= 1'b1;
    az <= 3'h6;
    n = 0;
    do tick(); while (start !== 1'b1);
    av <= 1'b0;
    check({31'h0, stall}, 32'h1);
    bus(1'b1, `EBG_IDX_HRST, 32'h4000_0000);
    check({31'h0, rei}, 32'h1);
    check({31'h0, stall}, 32'h0);
    n = 0;
    repeat (60) @(posedge clk_sys_i) n += (done === 1'b1);
    check(32'(n), 32'h0);
    rdq(`EBG_IDX_BANK, 32'h3F);
    finish_test();
  end
endmodule // ebg_bank_gap_test
